// *** logic/keypad_ops_cfg.svh ***
// keypad operation settings bank: offsets, reset values, codes, timing
// assumes inclusion by the package, the bank module and the checker
`ifndef KEYPAD_OPS_CFG_SVH
`define KEYPAD_OPS_CFG_SVH
// register indices; byte address is four times the index
`define KO_IDX_USER_DEFAULT_CONTROL 14'h0507
`define KO_IDX_MODEL_CODE_SELECT    14'h0508
`define KO_IDX_SPARE_SLOT           14'h050d
`define KO_IDX_POWER_UP_DIRECTION   14'h0527
`define KO_IDX_UNDERVOLT_PERMIT     14'h061f
`define KO_IDX_AUX_SUPPLY_DETECT    14'h11f8
`define KO_IDX_FREQ_ENTRY_MODE      14'h1200
`define KO_IDX_PANEL_DETACH_DETECT  14'h1201
`define KO_IDX_STATUS               14'h1202
`define KO_IDX_FREQ_EDIT            14'h1203
`define KO_IDX_INIT_SELECTOR        14'h1204
`define KO_IDX_FREQ_REF             14'h1205
`define KO_IDX_HELD_REF             14'h1206
// reset values
`define KO_RST_USER_DEFAULT_CONTROL 16'h0000
`define KO_RST_POWER_UP_DIRECTION   16'h0000
`define KO_RST_UNDERVOLT_PERMIT     16'h0000
`define KO_RST_AUX_SUPPLY_DETECT    16'h0000
`define KO_RST_FREQ_ENTRY_MODE      16'h0000
`define KO_RST_PANEL_DETACH_DETECT  16'h0000
`define KO_SPARE_READ_VALUE         16'h0000
// codes
`define KO_UDC_SAVE                 16'h0001
`define KO_UDC_CLEAR                16'h0002
`define KO_INIT_USER                16'd1110
`define KO_DO_FUNC_ALARM            8'd10
// status fields
`define KO_ST_STORE_VALID           0
`define KO_ST_LINK_FAULT            1
`define KO_ST_AUX_ALARM             2
`define KO_ST_UNDERVOLT             3
`define KO_ST_RUN_INHIBIT           4
`define KO_ST_INIT_REFUSED          5
`define KO_ST_DIRECTION             6
`define KO_ST_HOLD_ACTIVE           7
// timing
`define KO_CLK_HZ                   50000000
`define KO_HOLD_TIME_S              5
`endif

// *** logic/keypad_ops_pkg.sv ***
// keypad operation settings bank: shared types
// assumes the cfg header is on the include path
`include "keypad_ops_cfg.svh"
package keypad_ops_pkg;
  typedef logic [15:0] word16_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAVE,
    ST_CLEAR,
    ST_LOAD
  } store_state_t;
  localparam int NUM_PARAMS = 6;
  localparam int HOLD_CYCLES = `KO_HOLD_TIME_S * `KO_CLK_HZ;
endpackage : keypad_ops_pkg

// *** logic/keypad_ops_bank.sv ***
// keypad operation settings bank with a classic wishbone slave
// assumes a single 50 MHz clock; keypad signals are asynchronous pins
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "keypad_ops_cfg.svh"

module keypad_ops_bank
  import keypad_ops_pkg::*;
#(
  parameter int HOLD_COUNT = HOLD_CYCLES,
  parameter logic [15:0] MODEL_CODE_DEFAULT = 16'h0042 // arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        enter_key_i,
  input  wire logic        updown_key_i,
  input  wire logic        keypad_present_i,
  input  wire logic        aux_supply_ok_i,
  input  wire logic        main_supply_ok_i,
  input  wire logic        supply_low_state_i,
  input  wire logic        local_mode_i,
  input  wire logic [3:0]  primary_run_source_i,
  input  wire logic [3:0]  secondary_run_source_i,
  input  wire logic [7:0]  digital_output_function_select_i,
  input  wire logic        run_request_i,
  output logic             run_enable_o,
  output logic             coast_stop_o,
  output logic             reverse_o,
  output logic             keypad_link_fault_o,
  output logic             aux_supply_loss_alarm_o,
  output logic             minor_fault_do_o,
  output logic [15:0]      freq_ref_o,
  output logic             model_changed_o
);

  // settings as software sees them
  word16_t      user_default_control_ff;
  word16_t      model_code_select_ff;
  word16_t      power_up_direction_ff;
  word16_t      undervolt_write_permit_ff;
  word16_t      aux_supply_loss_detect_ff;
  word16_t      freq_entry_mode_ff;
  word16_t      panel_detach_detect_ff;
  word16_t      init_selector_ff;
  word16_t      freq_edit_ff;
  word16_t      held_ref_ff;
  // live view and saved copy of six settings
  // copy needs no reset: store_valid_ff guards it
  word16_t      live_ff [NUM_PARAMS];
  word16_t      store_ff [NUM_PARAMS];
  logic         store_valid_ff;
  logic         init_refused_ff;
  store_state_t state_ff;
  logic [31:0]  hold_cnt_ff;
  // pin synchronisers, three stages each
  logic [2:0]   enter_sync_ff;
  logic [2:0]   updown_sync_ff;
  logic [2:0]   present_sync_ff;
  logic [2:0]   aux_sync_ff;
  logic [2:0]   main_sync_ff;
  logic [2:0]   uv_sync_ff;
  logic [2:0]   local_sync_ff;
  // accepted levels start at each pin's idle value
  logic         enter_lvl_ff;
  logic         updown_lvl_ff;
  logic         present_lvl_ff;
  logic         aux_lvl_ff;
  logic         main_lvl_ff;
  logic         uv_lvl_ff;
  logic         local_lvl_ff;
  logic         dir_latched_ff;

  // three-stage sync; level accepted when stages two and three agree
  function automatic logic settle(input logic [2:0] s, input logic prev);
    settle = (s[1] == s[2]) ? s[2] : prev;
  endfunction : settle

  always_ff @(posedge clk_i) begin
    enter_sync_ff   <= {enter_sync_ff[1:0], enter_key_i};
    updown_sync_ff  <= {updown_sync_ff[1:0], updown_key_i};
    present_sync_ff <= {present_sync_ff[1:0], keypad_present_i};
    aux_sync_ff     <= {aux_sync_ff[1:0], aux_supply_ok_i};
    main_sync_ff    <= {main_sync_ff[1:0], main_supply_ok_i};
    uv_sync_ff      <= {uv_sync_ff[1:0], supply_low_state_i};
    local_sync_ff   <= {local_sync_ff[1:0], local_mode_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enter_lvl_ff   <= 1'b0;
      updown_lvl_ff  <= 1'b0;
      present_lvl_ff <= 1'b1;
      aux_lvl_ff     <= 1'b1;
      main_lvl_ff    <= 1'b1;
      uv_lvl_ff      <= 1'b0;
      local_lvl_ff   <= 1'b0;
    end else begin
      enter_lvl_ff   <= settle(enter_sync_ff, enter_lvl_ff);
      updown_lvl_ff  <= settle(updown_sync_ff, updown_lvl_ff);
      present_lvl_ff <= settle(present_sync_ff, present_lvl_ff);
      aux_lvl_ff     <= settle(aux_sync_ff, aux_lvl_ff);
      main_lvl_ff    <= settle(main_sync_ff, main_lvl_ff);
      uv_lvl_ff      <= settle(uv_sync_ff, uv_lvl_ff);
      local_lvl_ff   <= settle(local_sync_ff, local_lvl_ff);
    end
  end

  logic       enter_rise;
  logic       updown_rise;
  logic       keypad_source;
  logic       wr_req;
  logic       rd_req;
  logic       wr_ok;
  logic [13:0] idx;
  word16_t    wdata;

  // edge only once stages agree and the level was low
  assign enter_rise  = enter_sync_ff[2] == enter_sync_ff[1] &&
                       enter_sync_ff[2] && !enter_lvl_ff;
  assign updown_rise = updown_sync_ff[2] == updown_sync_ff[1] &&
                       updown_sync_ff[2] && !updown_lvl_ff;
  // detach and direction act only with keypad as source
  assign keypad_source = primary_run_source_i == 4'h0 ||
                         secondary_run_source_i == 4'h0 ||
                         local_lvl_ff;
  assign idx   = adr_i[15:2];
  // unselected byte lanes write as zero
  assign wdata = {sel_i[1] ? dat_i[15:8] : 8'h00,
                  sel_i[0] ? dat_i[7:0] : 8'h00};
  assign wr_req = cyc_i && stb_i && we_i && !ack_o;
  assign rd_req = cyc_i && stb_i && !we_i && !ack_o;
  // undervoltage write lock applies to settings, never to status
  assign wr_ok  = wr_req && (!uv_lvl_ff || undervolt_write_permit_ff[0]);

  // registered ack; the !ack_o term stops a held request
  // from being taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else ack_o <= cyc_i && stb_i && !ack_o;
  end

  // settings registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_up_direction_ff     <= `KO_RST_POWER_UP_DIRECTION;
      undervolt_write_permit_ff <= `KO_RST_UNDERVOLT_PERMIT;
      aux_supply_loss_detect_ff <= `KO_RST_AUX_SUPPLY_DETECT;
      freq_entry_mode_ff        <= `KO_RST_FREQ_ENTRY_MODE;
      panel_detach_detect_ff    <= `KO_RST_PANEL_DETACH_DETECT;
      model_code_select_ff      <= MODEL_CODE_DEFAULT;
      init_selector_ff          <= 16'h0000;
      freq_edit_ff              <= 16'h0000;
      model_changed_o           <= 1'b0;
    end else begin
      model_changed_o <= 1'b0;
      // reload runs in the ack cycle, when no write lands
      if (state_ff == ST_LOAD) begin
        power_up_direction_ff     <= store_ff[0];
        undervolt_write_permit_ff <= store_ff[1];
        aux_supply_loss_detect_ff <= store_ff[2];
        freq_entry_mode_ff        <= store_ff[3];
        panel_detach_detect_ff    <= store_ff[4];
        model_code_select_ff      <= store_ff[5];
        model_changed_o           <= 1'b1;
      end else if (wr_ok) begin
        if (idx == `KO_IDX_POWER_UP_DIRECTION) begin
          power_up_direction_ff <= wdata;
        end else if (idx == `KO_IDX_UNDERVOLT_PERMIT) begin
          undervolt_write_permit_ff <= wdata;
        end else if (idx == `KO_IDX_AUX_SUPPLY_DETECT) begin
          aux_supply_loss_detect_ff <= wdata;
        end else if (idx == `KO_IDX_FREQ_ENTRY_MODE) begin
          freq_entry_mode_ff <= wdata;
        end else if (idx == `KO_IDX_PANEL_DETACH_DETECT) begin
          panel_detach_detect_ff <= wdata;
        end else if (idx == `KO_IDX_MODEL_CODE_SELECT) begin
          model_code_select_ff <= wdata;
          // pulse tells the drive to recompute model-tied values
          model_changed_o      <= wdata != model_code_select_ff;
        end else if (idx == `KO_IDX_FREQ_EDIT) begin
          freq_edit_ff <= wdata;
        end else if (idx == `KO_IDX_INIT_SELECTOR) begin
          init_selector_ff <= wdata;
        end
      end
    end
  end

  // flat view of the live settings for the copy loop
  always_comb begin
    live_ff[0] = power_up_direction_ff;
    live_ff[1] = undervolt_write_permit_ff;
    live_ff[2] = aux_supply_loss_detect_ff;
    live_ff[3] = freq_entry_mode_ff;
    live_ff[4] = panel_detach_detect_ff;
    live_ff[5] = model_code_select_ff;
  end

  // user default store and its control sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff                <= ST_IDLE;
      user_default_control_ff <= `KO_RST_USER_DEFAULT_CONTROL;
      store_valid_ff          <= 1'b0;
      init_refused_ff         <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (wr_ok && idx == `KO_IDX_USER_DEFAULT_CONTROL) begin
            user_default_control_ff <= wdata;
            if (wdata == `KO_UDC_SAVE) state_ff <= ST_SAVE;
            else if (wdata == `KO_UDC_CLEAR) state_ff <= ST_CLEAR;
          end else if (wr_ok && idx == `KO_IDX_INIT_SELECTOR &&
                       wdata == `KO_INIT_USER) begin
            if (store_valid_ff) begin
              state_ff        <= ST_LOAD;
              init_refused_ff <= 1'b0;
            end else begin
              init_refused_ff <= 1'b1;
            end
          end
        end
        // one-cycle copy while the bus is acking
        ST_SAVE: begin
          for (int i = 0; i < NUM_PARAMS; i++) begin
            store_ff[i] <= live_ff[i];
          end
          store_valid_ff          <= 1'b1;
          user_default_control_ff <= 16'h0000;
          state_ff                <= ST_IDLE;
        end
        // erase also marks the store empty
        ST_CLEAR: begin
          for (int i = 0; i < NUM_PARAMS; i++) begin
            store_ff[i] <= 16'h0000;
          end
          store_valid_ff          <= 1'b0;
          user_default_control_ff <= 16'h0000;
          state_ff                <= ST_IDLE;
        end
        ST_LOAD: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // keypad frequency reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_ref_o  <= 16'h0000;
      held_ref_ff <= 16'h0000;
      hold_cnt_ff <= 32'h0;
    end else if (freq_entry_mode_ff[0]) begin
      freq_ref_o <= freq_edit_ff;
      // each up/down press restarts the hold window
      if (updown_rise) begin
        hold_cnt_ff <= HOLD_COUNT;
        held_ref_ff <= freq_edit_ff;
      end else if (hold_cnt_ff != 32'h0) begin
        hold_cnt_ff <= hold_cnt_ff - 32'h1;
        if (hold_cnt_ff == 32'h1) held_ref_ff <= freq_edit_ff;
      end
    end else if (enter_rise) begin
      freq_ref_o <= freq_edit_ff;
    end
  end

  logic detach_trip;
  logic aux_loss;
  // trip is combinational so run and coast react at once
  assign detach_trip = keypad_source && !present_lvl_ff &&
                       panel_detach_detect_ff[0];
  // backup loss only counts while main power is up
  assign aux_loss = aux_supply_loss_detect_ff[0] && main_lvl_ff &&
                    !aux_lvl_ff;

  // run, fault and alarm outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keypad_link_fault_o     <= 1'b0;
      aux_supply_loss_alarm_o <= 1'b0;
      minor_fault_do_o        <= 1'b0;
      run_enable_o            <= 1'b0;
      coast_stop_o            <= 1'b0;
      reverse_o               <= 1'b0;
      dir_latched_ff          <= 1'b0;
    end else begin
      // sticky fault; a trip wins over a clear
      if (detach_trip) keypad_link_fault_o <= 1'b1;
      else if (wr_req && idx == `KO_IDX_STATUS && wdata[`KO_ST_LINK_FAULT])
        keypad_link_fault_o <= 1'b0;
      aux_supply_loss_alarm_o <= aux_loss;
      // alarm is display-only, kept off alarm-function outputs
      minor_fault_do_o <= 1'b0 &&
        digital_output_function_select_i == `KO_DO_FUNC_ALARM;
      // coast also covers the trip cycle itself
      coast_stop_o <= keypad_link_fault_o || detach_trip;
      run_enable_o <= run_request_i && main_lvl_ff &&
                      !keypad_link_fault_o && !detach_trip;
      // direction taken once, at the first keypad source
      if (!dir_latched_ff && keypad_source) begin
        reverse_o      <= power_up_direction_ff[0];
        dir_latched_ff <= 1'b1;
      end
    end
  end

  // unmapped indices read as zero
  word16_t rd_val;
  always_comb begin
    rd_val = 16'h0000;
    if (idx == `KO_IDX_USER_DEFAULT_CONTROL) rd_val = user_default_control_ff;
    else if (idx == `KO_IDX_MODEL_CODE_SELECT) rd_val = model_code_select_ff;
    else if (idx == `KO_IDX_SPARE_SLOT) rd_val = `KO_SPARE_READ_VALUE;
    else if (idx == `KO_IDX_POWER_UP_DIRECTION) rd_val = power_up_direction_ff;
    else if (idx == `KO_IDX_UNDERVOLT_PERMIT) rd_val = undervolt_write_permit_ff;
    else if (idx == `KO_IDX_AUX_SUPPLY_DETECT) rd_val = aux_supply_loss_detect_ff;
    else if (idx == `KO_IDX_FREQ_ENTRY_MODE) rd_val = freq_entry_mode_ff;
    else if (idx == `KO_IDX_PANEL_DETACH_DETECT) rd_val = panel_detach_detect_ff;
    else if (idx == `KO_IDX_FREQ_EDIT) rd_val = freq_edit_ff;
    else if (idx == `KO_IDX_INIT_SELECTOR) rd_val = init_selector_ff;
    else if (idx == `KO_IDX_FREQ_REF) rd_val = freq_ref_o;
    else if (idx == `KO_IDX_HELD_REF) rd_val = held_ref_ff;
    else if (idx == `KO_IDX_STATUS) begin
      rd_val[`KO_ST_STORE_VALID]  = store_valid_ff;
      rd_val[`KO_ST_LINK_FAULT]   = keypad_link_fault_o;
      rd_val[`KO_ST_AUX_ALARM]    = aux_supply_loss_alarm_o;
      rd_val[`KO_ST_UNDERVOLT]    = uv_lvl_ff;
      rd_val[`KO_ST_RUN_INHIBIT]  = !main_lvl_ff;
      rd_val[`KO_ST_INIT_REFUSED] = init_refused_ff;
      rd_val[`KO_ST_DIRECTION]    = reverse_o;
      rd_val[`KO_ST_HOLD_ACTIVE]  = hold_cnt_ff != 32'h0;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 32'h0;
    else if (rd_req) dat_o <= {16'h0000, rd_val};
  end

endmodule : keypad_ops_bank
`default_nettype wire

// *** tb/keypad_ops_bank_sva.sv ***
// checker: bus timing and fault outputs of the keypad settings bank
// assumes binding to keypad_ops_bank, one clock, sync active-high reset
`timescale 1ns/100ps
`default_nettype none
`include "keypad_ops_cfg.svh"
module keypad_ops_bank_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [15:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        keypad_present_i,
  input wire logic        aux_supply_ok_i,
  input wire logic        main_supply_ok_i,
  input wire logic        local_mode_i,
  input wire logic [3:0]  primary_run_source_i,
  input wire logic [3:0]  secondary_run_source_i,
  input wire logic        run_enable_o,
  input wire logic        coast_stop_o,
  input wire logic        keypad_link_fault_o,
  input wire logic        aux_supply_loss_alarm_o,
  input wire logic        minor_fault_do_o,
  input wire logic        model_changed_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_taken;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_spare_read;
    ack_o && !we_i && adr_i[15:2] == `KO_IDX_SPARE_SLOT;
  endsequence
  chk_ack_once: assert property (s_taken |=> ack_o ##1 !ack_o)
    else $error("ack not one pulse one cycle after request");
  chk_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_spare_fixed: assert property (s_spare_read |->
    dat_o[15:0] == `KO_SPARE_READ_VALUE)
    else $error("spare slot read not fixed");
  chk_minor_quiet: assert property (aux_supply_loss_alarm_o |->
    !minor_fault_do_o)
    else $error("aux alarm drove minor fault output");
  // six cycles: three-flop sync, level register, output register, sampling cycle
  chk_backup_inhibit: assert property (!main_supply_ok_i [*6] |->
    !run_enable_o)
    else $error("run enabled without main supply");
  chk_fault_coast: assert property ($rose(keypad_link_fault_o) |->
    ##[0:2] (coast_stop_o && !run_enable_o))
    else $error("link fault without coast stop");
  chk_present_quiet: assert property (keypad_present_i [*8] |=>
    !$rose(keypad_link_fault_o))
    else $error("link fault with keypad present");
  chk_source_gate: assert property ((primary_run_source_i != 4'h0 &&
    secondary_run_source_i != 4'h0 && !local_mode_i) [*8] |=>
    !$rose(keypad_link_fault_o))
    else $error("link fault while keypad not run source");
  chk_aux_gate: assert property ((aux_supply_ok_i ||
    !main_supply_ok_i) [*8] |=> !$rose(aux_supply_loss_alarm_o))
    else $error("aux alarm without backup loss in main power");
  chk_model_pulse: assert property (model_changed_o |=>
    !model_changed_o)
    else $error("model change flag longer than one cycle");
endmodule : keypad_ops_bank_sva
bind keypad_ops_bank keypad_ops_bank_sva keypad_ops_bank_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .keypad_present_i(keypad_present_i), .aux_supply_ok_i(aux_supply_ok_i),
  .main_supply_ok_i(main_supply_ok_i), .local_mode_i(local_mode_i),
  .primary_run_source_i(primary_run_source_i),
  .secondary_run_source_i(secondary_run_source_i),
  .run_enable_o(run_enable_o), .coast_stop_o(coast_stop_o),
  .keypad_link_fault_o(keypad_link_fault_o),
  .aux_supply_loss_alarm_o(aux_supply_loss_alarm_o),
  .minor_fault_do_o(minor_fault_do_o), .model_changed_o(model_changed_o));
`default_nettype wire

// *** tb/keypad_panel_model.sv ***
// keypad panel model: enter and up/down keys, cable presence
// assumes key requests arrive as one-cycle pulses after a clock edge
`timescale 1ns/100ps
`default_nettype none
module keypad_panel_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] press_i,
  input  wire logic       detach_i,
  output logic            enter_key_o,
  output logic            updown_key_o,
  output logic            present_o
);
  logic [3:0] hold_ff = 4'h0;
  logic [1:0] key_ff  = 2'b00;
  // a press outlasts the three-flop synchroniser inside the bank
  always @(posedge clk_i) begin
    if (press_i != 2'b00) begin
      key_ff  <= press_i;
      hold_ff <= 4'h6;
    end else if (hold_ff != 4'h0) begin
      hold_ff <= hold_ff - 4'h1;
    end
  end
  assign enter_key_o  = (hold_ff != 4'h0) & key_ff[0];
  assign updown_key_o = (hold_ff != 4'h0) & key_ff[1];
  // pulled cable reads absent at once, no stale level kept
  assign present_o    = ~detach_i;
endmodule : keypad_panel_model
`default_nettype wire

// *** tb/keypad_operation_settings_bank_bench.sv ***
// bench: keypad settings bank driven over wishbone beside a panel model
// assumes the cfg header on the include path and the checker bound in
`timescale 1ns/100ps
`default_nettype none
module keypad_operation_settings_bank_bench;
  localparam logic [15:0] MODEL_DEF = 16'h0042; // arbitrary value
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic        we_i = 1'b0, ack_o, run_en, coast, rev, fault, alarm, minor;
  logic        enter, updown, present, mchg, mchg_seen = 1'b0;
  logic        aux_ok = 1'b1, main_ok = 1'b1, low = 1'b0, local_md = 1'b0;
  logic        run_req = 1'b1, detach = 1'b0;
  logic [1:0]  press = 2'b00;
  logic [3:0]  prim = 4'h1, sec = 4'h1;
  logic [15:0] adr_i = 16'h0000, fref;
  logic [31:0] dat_i = 32'h0, dat_o;
  int          fail_count = 0, total_checks = 0;
  keypad_ops_bank #(.HOLD_COUNT(20), .MODEL_CODE_DEFAULT(MODEL_DEF))
    keypad_ops_bank_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .enter_key_i(enter),
    .updown_key_i(updown), .keypad_present_i(present),
    .aux_supply_ok_i(aux_ok), .main_supply_ok_i(main_ok),
    .supply_low_state_i(low), .local_mode_i(local_md),
    .primary_run_source_i(prim), .secondary_run_source_i(sec),
    .digital_output_function_select_i(8'h0a), .run_request_i(run_req),
    .run_enable_o(run_en), .coast_stop_o(coast), .reverse_o(rev),
    .keypad_link_fault_o(fault), .aux_supply_loss_alarm_o(alarm),
    .minor_fault_do_o(minor), .freq_ref_o(fref), .model_changed_o(mchg));
  keypad_panel_model keypad_panel_model_inst (
    .clk_i(clk_i), .press_i(press), .detach_i(detach),
    .enter_key_o(enter), .updown_key_o(updown), .present_o(present));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (mchg === 1'b1) mchg_seen <= 1'b1;
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : expect_eq
  // waits for ack without assuming a latency; bounded by count
  task automatic wb_cycle(input logic w, input logic [13:0] idx,
                          input logic [15:0] wd, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {16'h0000, wd};
    do @(posedge clk_i); while (ack_o !== 1'b1 && n++ < 50);
    rd = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    expect_eq({15'h0000, ack_o}, 16'h0001);
  endtask : wb_cycle
  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    logic [15:0] r;
    wb_cycle(1'b1, idx, d, r);
  endtask : wr
  task automatic rd_chk(input logic [13:0] idx, input logic [15:0] exp);
    logic [15:0] r;
    wb_cycle(1'b0, idx, 16'h0000, r);
    expect_eq(r, exp);
  endtask : rd_chk
  task automatic st_chk(input int b, input logic e);
    logic [15:0] r;
    wb_cycle(1'b0, 14'h1202, 16'h0000, r);
    expect_eq({15'h0000, r[b]}, {15'h0000, e});
  endtask : st_chk
  task automatic bit_chk(input logic got, input logic e);
    expect_eq({15'h0000, got}, {15'h0000, e});
  endtask : bit_chk
  task automatic t_reset;
    rd_chk(14'h0507, 16'h0000);
    rd_chk(14'h0508, MODEL_DEF);
    rd_chk(14'h0527, 16'h0000);
    rd_chk(14'h061f, 16'h0000);
    rd_chk(14'h11f8, 16'h0000);
    rd_chk(14'h1200, 16'h0000);
    rd_chk(14'h1201, 16'h0000);
    wr(14'h050d, 16'hffff);
    rd_chk(14'h050d, 16'h0000);
    rd_chk(14'h0100, 16'h0000);
    $display("reset values test done");
  endtask : t_reset
  task automatic t_store;
    wr(14'h061f, 16'h0001);
    wr(14'h0507, 16'h0001);
    repeat (2) @(posedge clk_i);
    rd_chk(14'h0507, 16'h0000);
    st_chk(0, 1'b1);
    wr(14'h061f, 16'h0000);
    wr(14'h1204, 16'd1110);
    rd_chk(14'h061f, 16'h0001);
    wr(14'h0507, 16'h0002);
    repeat (2) @(posedge clk_i);
    rd_chk(14'h0507, 16'h0000);
    st_chk(0, 1'b0);
    wr(14'h061f, 16'h0001);
    wr(14'h1204, 16'd1110);
    st_chk(5, 1'b1);
    rd_chk(14'h061f, 16'h0001);
    wr(14'h061f, 16'h0000);
    mchg_seen <= 1'b0;
    wr(14'h0508, 16'h0055);
    repeat (2) @(posedge clk_i);
    bit_chk(mchg_seen, 1'b1);
    rd_chk(14'h0508, 16'h0055);
    $display("user store test done");
  endtask : t_store
  task automatic t_freq;
    int n;
    n = 0;
    wr(14'h1203, 16'h1234);
    rd_chk(14'h1205, 16'h0000);
    press <= 2'b01;
    @(posedge clk_i);
    press <= 2'b00;
    while (fref !== 16'h1234 && n++ < 20) @(posedge clk_i);
    expect_eq(fref, 16'h1234);
    wr(14'h1200, 16'h0001);
    wr(14'h1203, 16'h0567);
    rd_chk(14'h1205, 16'h0567);
    press <= 2'b10;
    @(posedge clk_i);
    press <= 2'b00;
    repeat (6) @(posedge clk_i);
    wr(14'h1203, 16'h0777);
    st_chk(7, 1'b1);
    repeat (30) @(posedge clk_i);
    st_chk(7, 1'b0);
    rd_chk(14'h1206, 16'h0777);
    $display("frequency entry test done");
  endtask : t_freq
  task automatic t_detach;
    int n;
    n = 0;
    wr(14'h1201, 16'h0001);
    detach <= 1'b1;
    repeat (10) @(posedge clk_i);
    bit_chk(fault, 1'b0);
    wr(14'h1201, 16'h0000);
    prim <= 4'h0;
    repeat (10) @(posedge clk_i);
    bit_chk(fault, 1'b0);
    bit_chk(run_en, 1'b1);
    detach <= 1'b0;
    repeat (5) @(posedge clk_i);
    wr(14'h1201, 16'h0001);
    detach <= 1'b1;
    while (fault !== 1'b1 && n++ < 20) @(posedge clk_i);
    bit_chk(fault, 1'b1);
    @(posedge clk_i);
    bit_chk(coast, 1'b1);
    bit_chk(run_en, 1'b0);
    detach <= 1'b0;
    repeat (5) @(posedge clk_i);
    wr(14'h1202, 16'h0002);
    @(posedge clk_i);
    bit_chk(fault, 1'b0);
    $display("keypad detach test done");
  endtask : t_detach
  task automatic t_power;
    int n;
    n = 0;
    low <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(14'h0527, 16'h0001);
    rd_chk(14'h0527, 16'h0000);
    low <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(14'h061f, 16'h0001);
    low <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(14'h0527, 16'h0001);
    rd_chk(14'h0527, 16'h0001);
    low <= 1'b0;
    aux_ok <= 1'b0;
    repeat (10) @(posedge clk_i);
    bit_chk(alarm, 1'b0);
    wr(14'h11f8, 16'h0001);
    while (alarm !== 1'b1 && n++ < 20) @(posedge clk_i);
    bit_chk(alarm, 1'b1);
    bit_chk(minor, 1'b0);
    aux_ok <= 1'b1;
    main_ok <= 1'b0;
    repeat (8) @(posedge clk_i);
    bit_chk(run_en, 1'b0);
    main_ok <= 1'b1;
    $display("supply test done");
  endtask : t_power
  task automatic t_dir;
    prim <= 4'h1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    bit_chk(rev, 1'b0);
    wr(14'h0527, 16'h0001);
    prim <= 4'h0;
    repeat (2) @(posedge clk_i);
    bit_chk(rev, 1'b1);
    st_chk(6, 1'b1);
    $display("direction test done");
  endtask : t_dir
  initial begin
    #(20 * 20000);
    fail_count++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // let the input synchronisers settle before any traffic
    repeat (4) @(posedge clk_i);
    t_reset;
    t_store;
    t_freq;
    t_detach;
    t_power;
    t_dir;
    conclude;
  end
endmodule : keypad_operation_settings_bank_bench
`default_nettype wire
